/* design/interval_timer.sv */
// Periodic down-counter that pulses tick once per COUNT cycles.
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(
	parameter int COUNT = 312
) (
	input wire logic clk_in,
	input wire logic rst_in,
	timer_if.timer tm
);
	localparam int W = $clog2(COUNT + 1);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic tick_q;
	logic tick_d;

	// Reload on restart or expiry; a restart suppresses the pending tick.
	always_comb begin
		tick_d = 1'b0;
		cnt_d = cnt_q - 1'b1;
		if (tm.restart || cnt_q == '0) begin
			cnt_d = W'(COUNT - 1);
			tick_d = !tm.restart;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_q <= W'(COUNT - 1);
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tm.tick = tick_q;
endmodule // interval_timer
`default_nettype wire

/* design/timer_if.sv */
// Restart and tick signals between the controller and an interval timer.
`timescale 1ns/100ps
`default_nettype none
interface timer_if;
	logic restart;
	logic tick;
	modport timer (input restart, output tick);
	modport user (output restart, input tick);
endinterface
`default_nettype wire

/* design/vram_host.sv */
// Host controller driving the random-access port of a 32-bit video DRAM.
`timescale 1ns/100ps
`default_nettype none
module vram_host
	import vram_host_pkg::*;
#(
	parameter int WAKE_LIMIT = WAKE_LIMIT_CYC,
	parameter int REF_INTERVAL = REF_INT_CYC
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic [2:0] cmd_in,
	input wire logic [ADDR_W-1:0] row_in,
	input wire logic [ADDR_W-1:0] col_in,
	input wire logic [DQ_W-1:0] data_in,
	input wire logic [DQ_W-1:0] bitmask_in,
	output logic ready_out,
	output logic rvalid_out,
	output logic [DQ_W-1:0] rdata_out,
	output logic init_done_out,
	output logic ras_n_out,
	output logic [CAS_W-1:0] cas_n_out,
	output logic [ADDR_W-1:0] addr_out,
	output logic mask_write_strobe_n_out,
	output logic special_function_select_out,
	output logic transfer_output_enable_n_out,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe_out,
	input wire logic [DQ_W-1:0] dq_in
);
	state_e st_q, st_d;
	cnt_t cnt_q, cnt_d;
	logic [WAKE_W-1:0] wake_q, wake_d;
	cmd_e cmd_q, cmd_d;
	logic [ADDR_W-1:0] row_q, row_d, col_q, col_d;
	logic [DQ_W-1:0] data_q, data_d, mask_q, mask_d;
	logic pend_q, pend_d, ref_pend_q, ref_pend_d, wake_need_q, wake_need_d;
	logic ready_q, ready_d, rvalid_q, rvalid_d, init_q, init_d;
	logic [DQ_W-1:0] rdata_q, rdata_d;
	logic ras_n_q, ras_n_d, cas_n_q, cas_n_d, we_n_q, we_n_d;
	logic dsf_q, dsf_d, oe_n_q, oe_n_d, dq_oe_q, dq_oe_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DQ_W-1:0] dq_q, dq_d;
	logic [DQ_W-1:0] s1_q, s2_q, s3_q, settled_q, settled_d;
	logic take, page_ok, ref_start;

	timer_if ref_tm ();
	timer_if ovd_tm ();

	// Free-running refresh pacing: one row every interval keeps all rows fresh.
	interval_timer #(.COUNT(REF_INTERVAL)) u_ref_timer ( // [RULE20]
		.clk_in(clk_in),
		.rst_in(rst_in),
		.tm(ref_tm)
	);

	// Watchdog restarted by every refresh; expiry forces a new wake-up.
	interval_timer #(.COUNT(WAKE_LIMIT)) u_ovd_timer (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.tm(ovd_tm)
	);

	assign ref_tm.restart = 1'b0;
	assign ovd_tm.restart = ref_start;

	function automatic logic page_class(input cmd_e c);
		// Only cycles with identical row-edge settings may share a page.
		return c == CMD_READ || c == CMD_WRITE || c == CMD_BLOCK_WRITE;
	endfunction

	// Data pins pass three flops; a value counts once stages two and three agree.
	always_comb begin
		settled_d = settled_q;
		if (s2_q == s3_q) begin
			settled_d = s3_q;
		end
	end

	// Sequencer: power-up, wake-up, access, page, refresh and precharge.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		wake_d = wake_q;
		cmd_d = cmd_q;
		row_d = row_q;
		col_d = col_q;
		data_d = data_q;
		mask_d = mask_q;
		pend_d = pend_q;
		init_d = init_q;
		rvalid_d = 1'b0;
		rdata_d = rdata_q;
		ref_start = 1'b0;
		ref_pend_d = ref_pend_q || ref_tm.tick;
		wake_need_d = wake_need_q || ovd_tm.tick;
		take = req_in && ready_q;
		page_ok = page_class(cmd_q) && page_class(cmd_e'(cmd_in)) &&
			row_in == row_q && !ref_pend_q && !wake_need_q; // [RULE18]
		if (take) begin
			cmd_d = cmd_e'(cmd_in);
			row_d = row_in;
			col_d = col_in;
			data_d = data_in;
			mask_d = bitmask_in;
			pend_d = 1'b1;
		end
		case (st_q)
			ST_POWERUP: begin
				if (cnt_q == '0) begin // [RULE6]
					st_d = ST_WAKE_RAS;
					cnt_d = cnt_t'(RAS_CYC - 1);
					wake_d = WAKE_W'(WAKE_CYCLES - 1);
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			ST_WAKE_RAS: begin
				if (cnt_q == '0) begin
					st_d = ST_WAKE_PRE;
					cnt_d = cnt_t'(RP_CYC - 1);
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			ST_WAKE_PRE: begin
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1;
				end else if (wake_q == '0) begin // [RULE6]
					st_d = ST_IDLE;
					init_d = 1'b1;
					ref_start = 1'b1;
					wake_need_d = 1'b0;
				end else begin
					wake_d = wake_q - 1'b1;
					st_d = ST_WAKE_RAS;
					cnt_d = cnt_t'(RAS_CYC - 1);
				end
			end
			ST_IDLE: begin
				if (wake_need_q) begin // [RULE7]
					st_d = ST_WAKE_RAS;
					init_d = 1'b0;
					cnt_d = cnt_t'(RAS_CYC - 1);
					wake_d = WAKE_W'(WAKE_CYCLES - 1);
				end else if (ref_pend_q) begin
					st_d = ST_REF_CAS;
					ref_start = 1'b1;
					ref_pend_d = ref_tm.tick; // A new tick beats the clear.
				end else if (pend_d) begin
					st_d = ST_ROW;
					pend_d = 1'b0;
				end
			end
			ST_ROW: st_d = ST_RAS;
			ST_RAS: st_d = ST_COL;
			ST_COL, ST_PAGE: begin
				st_d = ST_CAS;
				cnt_d = (cmd_q == CMD_READ) ? cnt_t'(READ_CAS_CYC - 1) :
					cnt_t'(WRITE_CAS_CYC - 1);
			end
			ST_CAS: begin
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1;
				end else begin
					if (cmd_q == CMD_READ) begin
						rvalid_d = 1'b1;
						rdata_d = settled_q; // [RULE1]
					end
					if (take && page_ok) begin
						st_d = ST_PAGE;
						pend_d = 1'b0;
					end else begin
						st_d = ST_PRE;
						cnt_d = cnt_t'(RP_CYC - 1);
					end
				end
			end
			ST_PRE: begin
				if (cnt_q == '0) begin
					st_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			ST_REF_CAS: begin
				st_d = ST_REF_RAS;
				cnt_d = cnt_t'(RAS_CYC - 1);
			end
			ST_REF_RAS: begin
				if (cnt_q == '0) begin
					st_d = ST_PRE;
					cnt_d = cnt_t'(RP_CYC - 1);
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: st_d = ST_POWERUP;
		endcase
		ready_d = !pend_d && !ref_pend_d && !wake_need_d && init_d &&
			(st_d == ST_IDLE ||
			(st_d == ST_CAS && cnt_d == '0 && page_class(cmd_d)));
	end

	// Pin levels follow the next state so they leave flops aligned with it.
	always_comb begin
		ras_n_d = 1'b1;
		cas_n_d = 1'b1;
		we_n_d = 1'b1;
		dsf_d = 1'b0;
		oe_n_d = 1'b1;
		dq_oe_d = 1'b0;
		dq_d = dq_q;
		addr_d = addr_q;
		case (st_d)
			ST_ROW, ST_RAS: begin
				ras_n_d = (st_d == ST_ROW);
				addr_d = row_d;
				// Low strobe at row fall makes the pins a bit mask.
				we_n_d = !(cmd_d == CMD_MASKED_WRITE ||
					cmd_d == CMD_MASKED_BLOCK); // [RULE2]
				dsf_d = (cmd_d == CMD_LOAD_COLOR); // [RULE4]
				dq_oe_d = !we_n_d;
				dq_d = mask_d;
			end
			ST_COL, ST_PAGE, ST_CAS: begin
				ras_n_d = 1'b0;
				cas_n_d = (st_d != ST_CAS);
				addr_d = col_d;
				// Column-edge select picks block write or colour load.
				dsf_d = (cmd_d == CMD_BLOCK_WRITE ||
					cmd_d == CMD_MASKED_BLOCK ||
					cmd_d == CMD_LOAD_COLOR); // [RULE3] [RULE4] [RULE21]
				// Strobe falls before the column edge: always an early write.
				we_n_d = (cmd_d == CMD_READ); // [RULE5] [RULE11] [RULE19]
				oe_n_d = !(cmd_d == CMD_READ && st_d == ST_CAS); // [RULE12]
				dq_oe_d = (cmd_d != CMD_READ);
				dq_d = data_d;
			end
			ST_WAKE_RAS: ras_n_d = 1'b0;
			ST_REF_CAS: cas_n_d = 1'b0; // [RULE8]
			ST_REF_RAS: begin
				cas_n_d = 1'b0;
				ras_n_d = 1'b0;
			end
			// Precharge raises the column strobe before any new row fall.
			ST_PRE: cas_n_d = 1'b1; // [RULE10] [RULE15]
			default: ras_n_d = 1'b1;
		endcase
	end

	// Register all state; pins come straight from these flops.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q <= ST_POWERUP;
			cnt_q <= cnt_t'(POWERUP_CYC - 1);
			wake_q <= '0;
			cmd_q <= CMD_READ;
			row_q <= '0;
			col_q <= '0;
			data_q <= '0;
			mask_q <= '0;
			pend_q <= 1'b0;
			ref_pend_q <= 1'b0;
			wake_need_q <= 1'b0;
			ready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			init_q <= 1'b0;
			ras_n_q <= 1'b1;
			cas_n_q <= 1'b1;
			we_n_q <= 1'b1;
			dsf_q <= 1'b0;
			oe_n_q <= 1'b1;
			dq_oe_q <= 1'b0;
			dq_q <= '0;
			addr_q <= '0;
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			settled_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wake_q <= wake_d;
			cmd_q <= cmd_d;
			row_q <= row_d;
			col_q <= col_d;
			data_q <= data_d;
			mask_q <= mask_d;
			pend_q <= pend_d;
			ref_pend_q <= ref_pend_d;
			wake_need_q <= wake_need_d;
			ready_q <= ready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			init_q <= init_d;
			ras_n_q <= ras_n_d;
			cas_n_q <= cas_n_d;
			we_n_q <= we_n_d;
			dsf_q <= dsf_d;
			oe_n_q <= oe_n_d;
			dq_oe_q <= dq_oe_d;
			dq_q <= dq_d;
			addr_q <= addr_d;
			s1_q <= dq_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			settled_q <= settled_d;
		end
	end

	assign ready_out = ready_q;
	assign rvalid_out = rvalid_q;
	assign rdata_out = rdata_q;
	assign init_done_out = init_q;
	assign ras_n_out = ras_n_q;
	assign cas_n_out = {CAS_W{cas_n_q}};
	assign addr_out = addr_q;
	assign mask_write_strobe_n_out = we_n_q;
	assign special_function_select_out = dsf_q;
	assign transfer_output_enable_n_out = oe_n_q;
	assign dq_out = dq_q;
	assign dq_oe_out = dq_oe_q;
endmodule // vram_host
`default_nettype wire

/* design/vram_host_pkg.sv */
// Constants, commands and timing counts for the video DRAM host controller.
// Functional notes
// RULE1 - Every access carries thirty-two data bits.
// RULE2 - Mask strobe at row fall selects per-bit mask.
// RULE3 - Function select high at column fall: block write.
// RULE4 - Select and strobe high at row: colour load.
// RULE5 - Device samples data at later falling strobe.
// RULE6 - Wait 100 us, then eight row cycles.
// RULE7 - Refresh overrun repeats the eight-cycle wake-up.
// RULE8 - Column-before-row cycle refreshes from internal counter.
// RULE9 - Device floats data while column strobe high.
// RULE10 - Column strobe high for precharge before row fall.
// RULE11 - Early write keeps device outputs open throughout.
// RULE12 - Late write needs output enable high.
// RULE13 - Read-write cycle drives read data first.
// RULE14 - Undefined outputs still give a valid write.
// RULE15 - Read outputs float when enable or column rises.
// RULE16 - Lowered enable after write re-drives read data.
// RULE17 - Column rising first keeps outputs open.
// RULE18 - Page mode mixes read and write columns.
// RULE19 - Read command held past column strobe rise; a page write after a read lowers the write strobe on that same edge.
// RULE20 - 512 row refreshes within every refresh period.
// RULE21 - Colour value kept for every block write.
package vram_host_pkg;
	localparam int DQ_W = 32;
	localparam int ADDR_W = 9;
	localparam int CAS_W = 4;
	localparam int CNT_W = 12;
	localparam int WAKE_W = 4;
	localparam int DQ_SYNC_DEPTH = 3;

	localparam int CLK_PERIOD_NS = 50;
	localparam int T_POWERUP_US = 100;
	localparam int WAKE_CYCLES = 8;
	localparam int T_REF_PERIOD_MS = 8;
	localparam int REF_ROWS = 512;
	localparam int T_WAKE_LIMIT_US = 16_700;
	localparam int T_RAS_NS = 80;
	localparam int T_RP_NS = 60;
	localparam int T_CAS_NS = 25;

	// Least times round up, the refresh interval (a longest time) rounds down.
	localparam int POWERUP_CYC =
		(T_POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REF_INT_CYC =
		(T_REF_PERIOD_MS * 1_000_000 / REF_ROWS) / CLK_PERIOD_NS;
	localparam int WAKE_LIMIT_CYC = (T_WAKE_LIMIT_US * 1000) / CLK_PERIOD_NS;
	localparam int RAS_CYC = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CAS_CYC =
		(T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Column low long enough for data to pass the synchroniser and settle.
	localparam int READ_CAS_CYC = DQ_SYNC_DEPTH + 3;

	typedef logic [CNT_W-1:0] cnt_t;

	typedef enum logic [2:0] {
		CMD_READ,
		CMD_WRITE,
		CMD_MASKED_WRITE,
		CMD_BLOCK_WRITE,
		CMD_MASKED_BLOCK,
		CMD_LOAD_COLOR
	} cmd_e;

	typedef enum logic [3:0] {
		ST_POWERUP,
		ST_WAKE_RAS,
		ST_WAKE_PRE,
		ST_IDLE,
		ST_ROW,
		ST_RAS,
		ST_COL,
		ST_CAS,
		ST_PAGE,
		ST_PRE,
		ST_REF_CAS,
		ST_REF_RAS
	} state_e;
endpackage

/* sim/vram_host_bench.sv */
// Self-checking bench for the video DRAM host controller.
`timescale 1ns/100ps
`default_nettype none
module vram_host_bench
	import vram_host_pkg::*;
;
	typedef struct {cmd_e c; logic [8:0] r, k; logic [31:0] d, m, e;} op_s;
	logic clk_in = 0, rst_in = 1, req_in = 0;
	logic [2:0] cmd_in = 0;
	logic [ADDR_W-1:0] row_in = 0, col_in = 0, addr_out;
	logic [DQ_W-1:0] data_in = 0, bitmask_in = 0, rdata_out, dq_out, dev_dq;
	logic ready_out, rvalid_out, init_done_out, ras_n_out, dq_oe_out;
	logic mask_write_strobe_n_out, special_function_select_out;
	logic transfer_output_enable_n_out;
	logic [CAS_W-1:0] cas_n_out;
	logic [DQ_W-1:0] got[$];
	int n_fail = 0, tests_run = 0;
	op_s ops [15] = '{
		'{CMD_WRITE, 9'h005, 9'h008, 32'hA5A5_0F0F, '0, '0},
		'{CMD_READ, 9'h005, 9'h008, '0, '0, 32'hA5A5_0F0F},
		'{CMD_MASKED_WRITE, 9'h005, 9'h008, 32'h1234_5678, 32'hFFFF_0000, '0},
		'{CMD_READ, 9'h005, 9'h008, '0, '0, 32'h1234_0F0F},
		'{CMD_LOAD_COLOR, 9'h005, 9'h000, 32'hC0DE_CAFE, '0, '0},
		'{CMD_WRITE, 9'h005, 9'h011, 32'h0000_1111, '0, '0},
		'{CMD_BLOCK_WRITE, 9'h005, 9'h010, 32'h0505_0505, '0, '0},
		'{CMD_READ, 9'h005, 9'h010, '0, '0, 32'hC0DE_CAFE},
		'{CMD_READ, 9'h005, 9'h011, '0, '0, 32'h0000_1111},
		'{CMD_READ, 9'h005, 9'h012, '0, '0, 32'hC0DE_CAFE},
		'{CMD_WRITE, 9'h005, 9'h014, 32'h0000_0000, '0, '0},
		'{CMD_MASKED_BLOCK, 9'h005, 9'h014, 32'h0101_0101, 32'h00FF_00FF, '0},
		'{CMD_READ, 9'h005, 9'h014, '0, '0, 32'h00DE_00FE},
		'{CMD_WRITE, 9'h1FF, 9'h1FF, 32'hFFFF_FFFF, '0, '0},
		'{CMD_READ, 9'h1FF, 9'h1FF, '0, '0, 32'hFFFF_FFFF}
	};
	vram_host #(.WAKE_LIMIT(400), .REF_INTERVAL(40)) DUT (
		.clk_in, .rst_in, .req_in, .cmd_in, .row_in, .col_in, .data_in,
		.bitmask_in, .ready_out, .rvalid_out, .rdata_out, .init_done_out,
		.ras_n_out, .cas_n_out, .addr_out, .mask_write_strobe_n_out,
		.special_function_select_out, .transfer_output_enable_n_out,
		.dq_out, .dq_oe_out, .dq_in(dq_oe_out ? dq_out : dev_dq)
	);
	vram_model dev (
		.ras_n_in(ras_n_out), .cas_n_in(cas_n_out), .addr_in(addr_out),
		.mask_write_strobe_n_in(mask_write_strobe_n_out),
		.special_function_select_in(special_function_select_out),
		.transfer_output_enable_n_in(transfer_output_enable_n_out),
		.dq_in(dq_out), .dq_out(dev_dq)
	);
	// Half-period toggle gives the 20 MHz clock.
	always #25 clk_in = ~clk_in;
	// Read words are collected mid-cycle, where the pulse has settled.
	always @(negedge clk_in) begin
		if (rvalid_out === 1'b1) got.push_back(rdata_out);
	end
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic hang;
		$display("Error wait expected handshake seen none");
		n_fail++;
		stop_test();
	endtask
	task automatic chk32(input string s, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", s, e, g);
			n_fail++;
		end
	endtask
	task automatic chk1(input string s, input logic e, g);
		tests_run++;
		if (g !== e) begin
			$display("Error %s expected %b seen %b", s, e, g);
			n_fail++;
		end
	endtask
	// Request held from one falling edge to the next, taken when ready.
	task automatic send(input op_s t);
		int n = 0;
		while (ready_out !== 1'b1 && n < 3000) begin
			@(negedge clk_in);
			n++;
		end
		if (n == 3000) hang();
		cmd_in = t.c;
		row_in = t.r;
		col_in = t.k;
		data_in = t.d;
		bitmask_in = t.m;
		req_in = 1;
		@(negedge clk_in);
		req_in = 0;
	endtask
	task automatic take(input logic [31:0] e);
		int n = 0;
		while (got.size() == 0 && n < 60) begin
			@(negedge clk_in);
			n++;
		end
		if (n == 60) hang();
		else chk32("rdata", e, got.pop_front());
	endtask
	// Table first, then a second reset and back-to-back page traffic.
	initial begin
		repeat (2) @(negedge clk_in);
		rst_in = 0;
		foreach (ops[i]) begin
			send(ops[i]);
			if (ops[i].c == CMD_READ) take(ops[i].e);
		end
		rst_in = 1;
		repeat (2) @(negedge clk_in);
		rst_in = 0;
		chk1("ras_n", 1, ras_n_out);
		chk1("dq_oe", 0, dq_oe_out);
		repeat (1990) @(negedge clk_in);
		chk1("init_done", 0, init_done_out);
		chk1("ready", 0, ready_out);
		send('{CMD_WRITE, 9'h007, 9'h01E, 32'h0BAD_F00D, '0, '0});
		send('{CMD_READ, 9'h007, 9'h01E, '0, '0, '0});
		send('{CMD_WRITE, 9'h007, 9'h01F, 32'h7654_3210, '0, '0});
		send('{CMD_READ, 9'h007, 9'h01F, '0, '0, '0});
		take(32'h0BAD_F00D);
		take(32'h7654_3210);
		chk1("refreshed", 1, dev.ref_q != '0);
		stop_test();
	end
endmodule // vram_host_bench
`default_nettype wire

/* sim/vram_host_props.sv */
// Pin-level property checker for the video DRAM host controller.
`timescale 1ns/100ps
`default_nettype none
module vram_host_props
	import vram_host_pkg::*;
#(
	parameter int REF_INTERVAL = REF_INT_CYC
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic rvalid_out,
	input wire logic init_done_out,
	input wire logic ras_n_out,
	input wire logic [CAS_W-1:0] cas_n_out,
	input wire logic mask_write_strobe_n_out,
	input wire logic special_function_select_out,
	input wire logic transfer_output_enable_n_out,
	input wire logic dq_oe_out
);
	int cyc_q;
	int wake_q;
	int gap_q;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Time since reset, row falls since wake-up began, and refresh gap.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cyc_q <= 0;
			wake_q <= 0;
			gap_q <= 0;
		end else begin
			if (cyc_q < POWERUP_CYC) cyc_q <= cyc_q + 1;
			// A re-wake drops done and the row strobe on one edge; count that fall.
			if ($fell(init_done_out)) wake_q <= $fell(ras_n_out) ? 1 : 0;
			else if ($fell(ras_n_out) && wake_q < 15) wake_q <= wake_q + 1;
			if (!init_done_out || ($fell(ras_n_out) && !cas_n_out[0])) gap_q <= 0;
			else gap_q <= gap_q + 1;
		end
	end
	cas_lanes_a: assert property (cas_n_out == {CAS_W{cas_n_out[0]}})
		else $error("column strobes differ");
	mask_drive_a: assert property ($fell(ras_n_out) && !mask_write_strobe_n_out
		|-> dq_oe_out && !special_function_select_out) else $error("bad mask");
	block_drive_a: assert property ($fell(cas_n_out[0]) && !ras_n_out &&
		special_function_select_out |-> dq_oe_out) else $error("bad block");
	load_strobe_a: assert property ($fell(ras_n_out) && cas_n_out[0] &&
		special_function_select_out |-> mask_write_strobe_n_out)
		else $error("bad colour load");
	early_write_a: assert property ($fell(cas_n_out[0]) && !ras_n_out &&
		!mask_write_strobe_n_out |-> $past(!mask_write_strobe_n_out))
		else $error("write strobe late");
	no_contend_a: assert property (dq_oe_out |-> transfer_output_enable_n_out)
		else $error("bus contention");
	read_hold_a: assert property (!transfer_output_enable_n_out |->
		mask_write_strobe_n_out && !cas_n_out[0]) else $error("read not held");
	ras_precharge_a: assert property ($fell(ras_n_out) && cas_n_out[0]
		|-> $past(ras_n_out, 2) && $past(cas_n_out[0], 2))
		else $error("short precharge");
	wake_count_a: assert property ($rose(init_done_out) |-> wake_q >= 8)
		else $error("too few wake cycles");
	powerup_wait_a: assert property (cyc_q < POWERUP_CYC - 1 |->
		ras_n_out && !init_done_out) else $error("wake-up too early");
	refresh_gap_a: assert property (gap_q < 2 * REF_INTERVAL)
		else $error("refresh overdue");
	cover property ($rose(init_done_out));
	cover property ($fell(ras_n_out) && !cas_n_out[0]);
	cover property (rvalid_out);
endmodule // vram_host_props
bind vram_host vram_host_props #(.REF_INTERVAL(REF_INTERVAL)) props_i (
	.clk_in, .rst_in, .rvalid_out, .init_done_out, .ras_n_out, .cas_n_out,
	.mask_write_strobe_n_out, .special_function_select_out,
	.transfer_output_enable_n_out, .dq_oe_out
);
`default_nettype wire

/* sim/vram_model.sv */
// Behavioural model of the 32-bit video DRAM random-access port.
`timescale 1ns/100ps
`default_nettype none
module vram_model
	import vram_host_pkg::*;
(
	input wire logic ras_n_in,
	input wire logic [CAS_W-1:0] cas_n_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic mask_write_strobe_n_in,
	input wire logic special_function_select_in,
	input wire logic transfer_output_enable_n_in,
	input wire logic [DQ_W-1:0] dq_in,
	output logic [DQ_W-1:0] dq_out
);
	logic [DQ_W-1:0] mem [logic [17:0]];
	logic [DQ_W-1:0] color_q, mask_q, rd_q = '0;
	logic [ADDR_W-1:0] row_q, col_q, ref_q = '0;
	logic load_q;
	// Masked merge into one cell; unwritten cells read as zero.
	task automatic put(input logic [8:0] c, input logic [31:0] d);
		logic [31:0] old;
		old = mem.exists({row_q, c}) ? mem[{row_q, c}] : '0;
		mem[{row_q, c}] = (old & ~mask_q) | (d & mask_q);
	endtask
	// Write function chosen by the modes latched at the two strobe edges.
	task automatic store(input logic blk);
		if (load_q) color_q = dq_in;
		else if (blk) begin
			for (int i = 0; i < 4; i++)
				if (dq_in[i]) put({col_q[8:2], 2'(i)}, color_q);
		end else put(col_q, dq_in);
	endtask
	// Row edge: refresh from the own counter, or latch row, mask and mode.
	always @(negedge ras_n_in) begin
		if (!cas_n_in[0]) ref_q = ref_q + 1;
		else begin
			row_q = addr_in;
			mask_q = mask_write_strobe_n_in ? '1 : dq_in;
			load_q = special_function_select_in && mask_write_strobe_n_in;
		end
	end
	// Column edge fetches the cell and takes early-write data.
	always @(negedge cas_n_in[0]) begin
		if (!ras_n_in) begin
			col_q = addr_in;
			rd_q = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : '0;
			if (!mask_write_strobe_n_in) store(special_function_select_in);
		end
	end
	// A strobe falling after the column edge takes data there instead.
	// The check waits a moment so a column rise on the same edge is seen.
	always @(negedge mask_write_strobe_n_in) begin
		#1;
		if (!ras_n_in && !cas_n_in[0]) store(special_function_select_in);
	end
	// Off the bus the inverse shows, so stale data can never pass as valid.
	assign dq_out = (!cas_n_in[0] && !transfer_output_enable_n_in &&
		mask_write_strobe_n_in) ? rd_q : ~rd_q;
endmodule // vram_model
`default_nettype wire
